// *** rtl/cpm_core.sv ***
// Cascaded position, velocity and current PI control core with APB registers
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpm_core #(
  parameter int CYCLE_CLKS = cpm_pkg::CYCLE_CLKS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Feedback and ramp generator, already on pclk
  input wire logic signed [31:0] act_pos,
  input wire logic signed [15:0] act_vel,
  input wire logic signed [15:0] act_cur,
  input wire logic signed [15:0] cur_a,
  input wire logic signed [15:0] cur_b,
  input wire logic [15:0] rotor_angle,
  input wire logic signed [15:0] ramp_vel,
  input wire logic signed [15:0] ramp_acc,
  // Drive command
  output logic [15:0] drive_cmd,
  output logic [15:0] field_angle,
  output logic cycle_done
);
  typedef struct packed {
    cpm_pkg::cpm_st_t st;
    logic [cpm_pkg::CNT_W-1:0] cnt;
    logic [7:0] mode;
    logic [7:0] sub;
    logic [31:0] tpos;
    logic [15:0] tvel;
    logic [15:0] tcur;
    logic [2:0][15:0] kp;
    logic [2:0][15:0] tn;
    logic [2:0][15:0] emax;
    logic [2:0][15:0] ymax;
    logic [2:0][31:0] acc;
    logic [15:0] vff;
    logic [15:0] aff;
    logic [15:0] uff;
    logic [15:0] ascl;
    logic [15:0] l07;
    logic [15:0] l09;
    logic [15:0] l0a;
    logic [15:0] irat;
    logic [15:0] uref;
    logic [15:0] vsp;
    logic [15:0] csp;
    logic [15:0] drive;
    logic [15:0] angle;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic done;
    logic tuned;
  } cpm_state_t;

  cpm_state_t s;
  cpm_state_t next_s;

  logic pos_m, vel_m, trq_m, pos_act, vel_act, new_sel, wr, tick, sat, hold;
  logic [1:0] idx;
  logic [15:0] kp_u, tn_u, emax_u, lim;
  logic signed [31:0] sp, act, e, p, ai, sum, lim_s, y, dsum, dlim;
  logic signed [31:0] acc_n, vff_t, aff_t, uff_t;
  logic signed [63:0] prod, den, quo;
  logic [39:0] sq, rf, dif;

  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v > cpm_pkg::S16_MAX) begin
      return cpm_pkg::S16_MAX[15:0];
    end else if (v < cpm_pkg::S16_MIN) begin
      return cpm_pkg::S16_MIN[15:0];
    end
    return v[15:0];
  endfunction

  // Mode decode
  assign pos_m = s.mode inside {cpm_pkg::M_PP, cpm_pkg::M_HM, cpm_pkg::M_IP, cpm_pkg::M_CSP};
  assign vel_m = s.mode inside {cpm_pkg::M_VL, cpm_pkg::M_PV, cpm_pkg::M_CSV};
  assign trq_m = s.mode inside {cpm_pkg::M_TQ, cpm_pkg::M_CST};
  assign pos_act = pos_m || (vel_m && s.sub[cpm_pkg::SB_POSV]);
  assign vel_act = !(trq_m && s.sub[cpm_pkg::SB_RT]);
  assign new_sel = s.sub[cpm_pkg::SB_CL] ? (s.l07 == '0) : (s.l09 == '0);
  assign wr = psel && penable && s.pready && pwrite;
  assign tick = (s.st == cpm_pkg::ST_WAIT) && (s.cnt == cpm_pkg::CNT_W'(CYCLE_CLKS - 1));

  // One shared PI datapath, stepped through the three loops
  assign idx = (s.st == cpm_pkg::ST_POS) ? 2'd0 : ((s.st == cpm_pkg::ST_VEL) ? 2'd1 : 2'd2);
  assign kp_u = (idx == 2'd2 && !new_sel) ? s.l09 : s.kp[idx];
  assign tn_u = (idx == 2'd2 && !new_sel) ? s.l0a : s.tn[idx];
  assign emax_u = (s.emax[idx] == '0) ? 16'h0001 : s.emax[idx];
  // Speed-limited torque: velocity output never exceeds the torque target
  assign lim = (idx == 2'd1 && trq_m && (16'(s.tcur[15] ? -s.tcur : s.tcur) < s.ymax[1])) ?
               16'(s.tcur[15] ? -s.tcur : s.tcur) : s.ymax[idx];
  assign sp = (idx == 2'd0) ? $signed(s.tpos) :
              ((idx == 2'd1) ? 32'($signed(s.vsp)) : 32'($signed(s.csp)));
  assign act = (idx == 2'd0) ? act_pos : ((idx == 2'd1) ? 32'(act_vel) : 32'(act_cur));
  assign e = sp - act;
  // deviation emax maps to ymax at 100 percent
  assign prod = 64'(e) * 64'($signed({1'b0, kp_u})) * 64'($signed({1'b0, lim}));
  assign den = {48'h0, emax_u} * 64'(cpm_pkg::PCT);
  assign quo = prod / den;
  assign p = quo[31:0];
  // integral weight 1/Tn, off at zero
  assign ai = (tn_u == '0) ? '0 : $signed(s.acc[idx]) + p / $signed({16'h0, tn_u});
  assign sum = p + ai;
  assign lim_s = $signed({16'h0, lim});
  assign sat = (sum > lim_s) || (sum < -lim_s);
  assign y = (sum > lim_s) ? lim_s : ((sum < -lim_s) ? -lim_s : sum);
  // freeze integrator pushing into the limit
  assign hold = sat && (p != '0) && (p[31] == sum[31]);
  assign acc_n = (tn_u == '0) ? '0 : (hold ? $signed(s.acc[idx]) : ai);

  assign vff_t = 32'((48'(ramp_vel) * 48'($signed({1'b0, s.vff}))) / 48'(cpm_pkg::PERMIL));
  // half factor gives half current at once
  assign aff_t = 32'((64'(ramp_acc) * 64'($signed({1'b0, s.ascl})) *
                 64'($signed({1'b0, s.aff}))) / 64'(cpm_pkg::PERMIL));
  assign uff_t = $signed(32'((48'(s.uref) * 48'(s.uff)) / 48'(cpm_pkg::PERMIL)));
  assign dsum = y + uff_t;
  assign dlim = $signed({16'h0, s.ymax[2]});

  // tuning check, squared form avoids a root
  assign sq = 40'(32'(cur_a) * 32'(cur_a)) + 40'(32'(cur_b) * 32'(cur_b));
  assign rf = 40'(s.irat) * 40'(s.irat) * cpm_pkg::RMS_DIV_SQ;
  assign dif = (sq > rf) ? sq - rf : rf - sq;

  always_comb begin
    logic hit;
    logic [31:0] rd;
    hit = 1'b0;
    rd = '0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.pslverr = 1'b0;
    // Count through the loop stages too, so the period stays fixed
    next_s.cnt = s.cnt + 1'b1;
    case (s.st)
      cpm_pkg::ST_BOOT: begin
        if (new_sel) begin
          next_s.kp[2] = s.l09;
          next_s.tn[2] = s.l0a;
        end
        next_s.cnt = '0;
        next_s.st = cpm_pkg::ST_WAIT;
      end
      cpm_pkg::ST_WAIT: begin
        if (tick) begin
          next_s.cnt = '0;
          next_s.tuned = (dif <= (rf >> cpm_pkg::TUNE_SHIFT));
          next_s.st = cpm_pkg::ST_POS;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      cpm_pkg::ST_POS: begin
        if (pos_act) begin
          next_s.acc[0] = acc_n;
          next_s.vsp = sat16(y + vff_t);
        end else begin
          next_s.vsp = s.tvel;
        end
        next_s.st = cpm_pkg::ST_VEL;
      end
      cpm_pkg::ST_VEL: begin
        // no acceleration feed-forward in torque modes
        if (vel_act) begin
          next_s.acc[1] = acc_n;
          next_s.csp = sat16(y + (trq_m ? 32'sh0 : aff_t));
        end else begin
          next_s.csp = s.tcur;
        end
        next_s.st = cpm_pkg::ST_CUR;
      end
      cpm_pkg::ST_CUR: begin
        next_s.acc[2] = acc_n;
        next_s.drive = sat16((dsum > dlim) ? dlim : ((dsum < -dlim) ? -dlim : dsum));
        // field a quarter turn from rotor, ahead for positive csp and behind for negative csp
        next_s.angle = s.csp[15] ? rotor_angle - cpm_pkg::QTR : rotor_angle + cpm_pkg::QTR;
        next_s.done = 1'b1;
        next_s.st = cpm_pkg::ST_WAIT;
      end
      default: begin
        next_s.st = cpm_pkg::ST_BOOT;
      end
    endcase

    // Register decode, one wait state before every answer
    case (paddr)
      cpm_pkg::A_CTRL: begin
        hit = 1'b1;
        rd = {16'h0, s.sub, s.mode};
      end
      cpm_pkg::A_TPOS: begin
        hit = 1'b1;
        rd = s.tpos;
      end
      cpm_pkg::A_TVC: begin
        hit = 1'b1;
        rd = {s.tcur, s.tvel};
      end
      cpm_pkg::A_FF: begin
        hit = 1'b1;
        rd = {s.aff, s.vff};
      end
      cpm_pkg::A_FF2: begin
        hit = 1'b1;
        rd = {s.ascl, s.uff};
      end
      cpm_pkg::A_LEG: begin
        hit = 1'b1;
        rd = {s.l09, s.l07};
      end
      cpm_pkg::A_LEG2: begin
        hit = 1'b1;
        rd = {s.irat, s.l0a};
      end
      cpm_pkg::A_STAT: begin
        hit = 1'b1;
        rd = {24'h0, s.tuned, new_sel, pos_act, vel_act, 1'b0, s.st};
      end
      cpm_pkg::A_OUT: begin
        hit = 1'b1;
        rd = {s.angle, s.drive};
      end
      cpm_pkg::A_UREF: begin
        hit = 1'b1;
        rd = {16'h0, s.uref};
      end
      default: begin
      end
    endcase
    for (int i = 0; i < 3; i++) begin
      if (paddr == cpm_pkg::A_PI + 8'(i) * cpm_pkg::PI_STEP) begin
        hit = 1'b1;
        rd = {s.tn[i], s.kp[i]};
        if (wr) begin
          next_s.kp[i] = pwdata[15:0];
          next_s.tn[i] = pwdata[31:16];
        end
      end
      if (paddr == cpm_pkg::A_LIM + 8'(i) * cpm_pkg::PI_STEP) begin
        hit = 1'b1;
        rd = {s.ymax[i], s.emax[i]};
        if (wr) begin
          next_s.emax[i] = pwdata[15:0];
          next_s.ymax[i] = pwdata[31:16];
        end
      end
    end
    if (wr) begin
      case (paddr)
        cpm_pkg::A_CTRL: begin
          next_s.mode = pwdata[7:0];
          next_s.sub = pwdata[15:8];
          if (pwdata[cpm_pkg::B_RESTART]) begin
            next_s.st = cpm_pkg::ST_BOOT;
          end
        end
        cpm_pkg::A_TPOS: begin
          next_s.tpos = pwdata;
        end
        cpm_pkg::A_TVC: begin
          next_s.tvel = pwdata[15:0];
          next_s.tcur = pwdata[31:16];
        end
        cpm_pkg::A_FF: begin
          next_s.vff = pwdata[15:0];
          next_s.aff = pwdata[31:16];
        end
        cpm_pkg::A_FF2: begin
          next_s.uff = pwdata[15:0];
          next_s.ascl = pwdata[31:16];
        end
        cpm_pkg::A_LEG: begin
          next_s.l07 = pwdata[15:0];
          next_s.l09 = pwdata[31:16];
        end
        cpm_pkg::A_LEG2: begin
          next_s.l0a = pwdata[15:0];
          next_s.irat = pwdata[31:16];
        end
        cpm_pkg::A_UREF: begin
          next_s.uref = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    next_s.pready = psel && penable && !s.pready;
    if (psel && penable && !s.pready) begin
      next_s.prdata = pwrite ? 32'h0 : rd;
      next_s.pslverr = !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= cpm_pkg::ST_BOOT;
      s.kp <= {3{cpm_pkg::KP_DEF}};
      s.emax <= {3{cpm_pkg::EMAX_DEF}};
      s.ymax <= {3{cpm_pkg::YMAX_DEF}};
      s.uff <= cpm_pkg::UFF_DEF;
      s.l07 <= cpm_pkg::LEG_DEF;
      s.l09 <= cpm_pkg::LEG_DEF;
      s.irat <= cpm_pkg::IRAT_DEF;
      s.uref <= cpm_pkg::UREF_DEF;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign drive_cmd = s.drive;
  assign field_angle = s.angle;
  assign cycle_done = s.done;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cascade;
    (s.st == cpm_pkg::ST_POS) ##1 (s.st == cpm_pkg::ST_VEL) ##1
    (s.st == cpm_pkg::ST_CUR) ##1 (s.st == cpm_pkg::ST_WAIT && s.done);
  endsequence
  property p_cascade;
    tick && !wr |=> s_cascade;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade order broken");
  property p_cur_run;
    (s.st == cpm_pkg::ST_VEL) && !wr |=> (s.st == cpm_pkg::ST_CUR) ##1 s.done;
  endproperty
  a_cur_run: assert property (p_cur_run) else $error("current loop skipped");
  property p_vel_off;
    (s.st == cpm_pkg::ST_VEL) && !vel_act |=> (s.csp == $past(s.tcur));
  endproperty
  a_vel_off: assert property (p_vel_off) else $error("velocity loop not bypassed");
  property p_pos_off;
    (s.st == cpm_pkg::ST_POS) && !pos_act |=> (s.vsp == $past(s.tvel));
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("position loop not bypassed");
  property p_convert;
    (s.st == cpm_pkg::ST_BOOT) && new_sel && !wr |=>
      (s.kp[2] == $past(s.l09)) && (s.tn[2] == $past(s.l0a));
  endproperty
  a_convert: assert property (p_convert) else $error("legacy values not converted");
  property p_clamp;
    s.done |-> ($signed(s.drive) <= $signed({16'h0, $past(s.ymax[2])})) &&
               ($signed(s.drive) >= -$signed({16'h0, $past(s.ymax[2])}));
  endproperty
  a_clamp: assert property (p_clamp) else $error("drive above PWM limit");
  property p_tn_zero;
    (s.st == cpm_pkg::ST_CUR) && (tn_u == '0) |=> (s.acc[2] == '0);
  endproperty
  a_tn_zero: assert property (p_tn_zero) else $error("integral kept at zero reset time");
  property p_windup;
    (s.st == cpm_pkg::ST_CUR) && (tn_u != '0) && hold |=> $stable(s.acc[2]);
  endproperty
  a_windup: assert property (p_windup) else $error("integrator wound up");
endmodule
`default_nettype wire

// *** rtl/cpm_pkg.sv ***
// Constants, register map and state type of the cascaded PI motor control core
package cpm_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CYCLE_US = 50;
  localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int PCT = 100;
  localparam int PERMIL = 1000;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TPOS = 8'h04;
  localparam logic [7:0] A_TVC = 8'h08;
  localparam logic [7:0] A_PI = 8'h0C;
  localparam logic [7:0] A_LIM = 8'h10;
  localparam logic [7:0] PI_STEP = 8'h08;
  localparam logic [7:0] A_FF = 8'h24;
  localparam logic [7:0] A_FF2 = 8'h28;
  localparam logic [7:0] A_LEG = 8'h2C;
  localparam logic [7:0] A_LEG2 = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  localparam logic [7:0] A_OUT = 8'h38;
  localparam logic [7:0] A_UREF = 8'h3C;
  // Field positions
  localparam int B_RESTART = 16;
  localparam int SB_CL = 0;
  localparam int SB_POSV = 1;
  localparam int SB_RT = 5;
  // Operating mode codes
  localparam logic [7:0] M_PP = 8'h01;
  localparam logic [7:0] M_VL = 8'h02;
  localparam logic [7:0] M_PV = 8'h03;
  localparam logic [7:0] M_TQ = 8'h04;
  localparam logic [7:0] M_HM = 8'h06;
  localparam logic [7:0] M_IP = 8'h07;
  localparam logic [7:0] M_CSP = 8'h08;
  localparam logic [7:0] M_CSV = 8'h09;
  localparam logic [7:0] M_CST = 8'h0A;
  // Reset values
  localparam logic [15:0] KP_DEF = 16'h0064;
  localparam logic [15:0] EMAX_DEF = 16'h03E8;
  localparam logic [15:0] YMAX_DEF = 16'h4000;
  localparam logic [15:0] UFF_DEF = 16'h03E8;
  localparam logic [15:0] LEG_DEF = 16'h0001;
  localparam logic [15:0] IRAT_DEF = 16'h03E8;
  localparam logic [15:0] UREF_DEF = 16'h1000;
  // Arithmetic constants
  localparam logic [15:0] QTR = 16'h4000;
  localparam logic [39:0] RMS_DIV_SQ = 40'h4;
  localparam int TUNE_SHIFT = 4;
  localparam logic signed [31:0] S16_MAX = 32'sh0000_7FFF;
  localparam logic signed [31:0] S16_MIN = -32'sh0000_8000;
  typedef enum logic [2:0] {ST_BOOT, ST_WAIT, ST_POS, ST_VEL, ST_CUR} cpm_st_t;
endpackage

// *** verification/cascaded_pi_motor_control_bench.sv ***
// Self-checking testbench of the cascaded PI motor control core
`timescale 1ns/1ps
`default_nettype none
module cascaded_pi_motor_control_bench;
  localparam int NCYC = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, cycle_done, hold;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic signed [31:0] act_pos;
  logic signed [15:0] act_vel, act_cur, cur_a, cur_b, ramp_vel, ramp_acc, tune_a;
  logic [15:0] rotor_angle, drive_cmd, field_angle, d1;
  int bad_count, checks_done, n, cnt;
  // Mode, submode, position loop on, velocity loop on
  logic [17:0] tbl [13] = '{18'h00407, 18'h00805, 18'h0080F, 18'h00C0F, 18'h01005,
    18'h01084, 18'h01807, 18'h01C07, 18'h02007, 18'h02405, 18'h0240F, 18'h02884, 18'h02805};
  // Gain, target current, expected drive, expected field angle
  logic [63:0] gtab [5] = '{64'h0064_01F4_03E8_5000, 64'h0064_03E8_07D0_5000,
    64'h0019_03E8_01F4_5000, 64'h0064_0BB8_07D0_5000, 64'h0064_F448_F830_D000};

  cpm_core #(.CYCLE_CLKS(NCYC)) cpm_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .act_pos(act_pos), .act_vel(act_vel),
    .act_cur(act_cur), .cur_a(cur_a), .cur_b(cur_b), .rotor_angle(rotor_angle),
    .ramp_vel(ramp_vel), .ramp_acc(ramp_acc), .drive_cmd(drive_cmd),
    .field_angle(field_angle), .cycle_done(cycle_done));
  cpm_motor_model cpm_motor_model_i (.pclk(pclk), .presetn(presetn), .hold(hold),
    .tune_a(tune_a), .drive_cmd(drive_cmd), .cycle_done(cycle_done), .act_pos(act_pos),
    .act_vel(act_vel), .act_cur(act_cur), .cur_a(cur_a), .cur_b(cur_b),
    .rotor_angle(rotor_angle));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is sampled high; no fixed wait assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      conclude();
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int k);
    repeat (k) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (cycle_done !== 1'b1 && n < 200);
      if (cycle_done !== 1'b1) begin
        bad_count++;
        conclude();
      end
    end
  endtask

  task automatic dchk(input logic [15:0] e);
    cyc(2);
    chk({16'h0000, drive_cmd}, {16'h0000, e});
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hold} = '0;
    {ramp_vel, ramp_acc, tune_a} = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, cpm_pkg::A_PI, 0);
    chk({16'h0000, q[15:0]}, {16'h0000, cpm_pkg::KP_DEF});
    apb(0, cpm_pkg::A_LIM, 0);
    chk(q, {cpm_pkg::YMAX_DEF, cpm_pkg::EMAX_DEF});
    apb(0, cpm_pkg::A_FF2, 0);
    chk({16'h0000, q[15:0]}, {16'h0000, cpm_pkg::UFF_DEF});
    apb(0, cpm_pkg::A_LEG, 0);
    chk(q, {cpm_pkg::LEG_DEF, cpm_pkg::LEG_DEF});
    apb(0, cpm_pkg::A_UREF, 0);
    chk(q, {16'h0000, cpm_pkg::UREF_DEF});
    apb(0, cpm_pkg::A_STAT, 0);
    chk({31'h0, q[6]}, 32'h0);
    apb(0, 8'hFC, 0);
    chk({31'h0, perr}, 32'h1);
    chk(q, 32'h0);
    cyc(1);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (cycle_done !== 1'b1 && cnt < 100);
    chk(cnt, NCYC);
    $display("test registers and cycle done");
    for (int i = 0; i < 13; i++) begin
      apb(1, cpm_pkg::A_CTRL, {16'h0000, tbl[i][9:2], tbl[i][17:10]});
      cyc(2);
      apb(0, cpm_pkg::A_STAT, 0);
      chk({30'h0, q[5:4]}, {30'h0, tbl[i][1:0]});
    end
    $display("test loop enables done");
    hold <= 1'b1;
    apb(1, cpm_pkg::A_FF, 0);
    apb(1, cpm_pkg::A_FF2, 0);
    apb(1, 8'h20, 32'h07D0_03E8);
    apb(1, cpm_pkg::A_LEG, 32'h0032_0001);
    apb(1, cpm_pkg::A_LEG2, {cpm_pkg::IRAT_DEF, 16'h0000});
    apb(1, cpm_pkg::A_TVC, 32'h01F4_0000);
    apb(1, cpm_pkg::A_CTRL, 32'h0000_2104);
    dchk(16'h01F4);
    chk({16'h0000, field_angle}, 32'h5000);
    // Master zeroes the selector, then restarts to trigger conversion
    apb(1, cpm_pkg::A_LEG, 32'h0032_0000);
    // Restart lands just after a cycle ends, clear of the loop stages
    cyc(1);
    apb(1, cpm_pkg::A_CTRL, 32'h0001_2104);
    dchk(16'h01F4);
    apb(0, cpm_pkg::A_STAT, 0);
    chk({31'h0, q[6]}, 32'h1);
    apb(0, 8'h1C, 0);
    chk(q, 32'h0000_0032);
    $display("test parameter sets done");
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h1C, {16'h0000, gtab[i][63:48]});
      apb(1, cpm_pkg::A_TVC, {gtab[i][47:32], 16'h0000});
      dchk(gtab[i][31:16]);
      chk({16'h0000, field_angle}, {16'h0000, gtab[i][15:0]});
    end
    apb(1, 8'h1C, 32'h0001_0064);
    apb(1, cpm_pkg::A_TVC, 32'h0064_0000);
    cyc(2);
    d1 = drive_cmd;
    cyc(2);
    chk({31'h0, $signed(drive_cmd) > $signed(d1)}, 32'h1);
    apb(1, 8'h1C, 32'h0000_0064);
    apb(1, cpm_pkg::A_TVC, 32'h01F4_0000);
    apb(1, cpm_pkg::A_FF2, {16'h0000, cpm_pkg::UFF_DEF});
    cyc(2);
    chk({16'h0000, drive_cmd}, 32'h0000_07D0);
    $display("test current loop done");
    apb(1, cpm_pkg::A_FF2, 32'h000A_0000);
    apb(1, cpm_pkg::A_FF, 32'h01F4_0000);
    ramp_acc <= 16'sh0064;
    apb(1, cpm_pkg::A_TVC, 0);
    apb(1, cpm_pkg::A_CTRL, 32'h0000_0102);
    dchk(16'h03E8);
    apb(1, cpm_pkg::A_CTRL, 32'h0000_0104);
    dchk(16'h0000);
    ramp_acc <= 16'sh0000;
    ramp_vel <= 16'sh00C8;
    apb(1, cpm_pkg::A_FF, 32'h0000_01F4);
    apb(1, 8'h18, 32'h03E8_03E8);
    apb(1, cpm_pkg::A_TPOS, 0);
    apb(1, cpm_pkg::A_CTRL, 32'h0000_0303);
    dchk(16'h00C8);
    apb(0, cpm_pkg::A_OUT, 0);
    chk(q, 32'h5000_00C8);
    apb(1, cpm_pkg::A_CTRL, 32'h0000_0103);
    dchk(16'h0000);
    $display("test feed forward done");
    tune_a <= 16'sh07D0;
    cyc(2);
    apb(0, cpm_pkg::A_STAT, 0);
    chk({31'h0, q[7]}, 32'h1);
    tune_a <= 16'sh0000;
    cyc(2);
    apb(0, cpm_pkg::A_STAT, 0);
    chk({31'h0, q[7]}, 32'h0);
    $display("test tuning flag done");
    conclude();
  end
endmodule
`default_nettype wire

// *** verification/cpm_motor_model.sv ***
// Behavioural motor and feedback model facing the control core
`timescale 1ns/1ps
`default_nettype none
module cpm_motor_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control of the feedback
  input wire logic hold,
  input wire logic signed [15:0] tune_a,
  // Command from the core
  input wire logic [15:0] drive_cmd,
  input wire logic cycle_done,
  // Feedback to the core
  output logic signed [31:0] act_pos,
  output logic signed [15:0] act_vel,
  output logic signed [15:0] act_cur,
  output logic signed [15:0] cur_a,
  output logic signed [15:0] cur_b,
  output logic [15:0] rotor_angle
);
  // Crude plant: current lags the command by one control cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_pos <= '0;
      act_vel <= '0;
      act_cur <= '0;
      cur_a <= '0;
      cur_b <= '0;
      rotor_angle <= 16'h1000;
    end else if (hold) begin
      act_pos <= '0;
      act_vel <= '0;
      act_cur <= '0;
      cur_a <= tune_a;
      cur_b <= '0;
      rotor_angle <= 16'h1000;
    end else if (cycle_done) begin
      act_cur <= $signed(drive_cmd) >>> 1;
      act_vel <= act_vel + (act_cur >>> 4);
      act_pos <= act_pos + 32'(act_vel);
      rotor_angle <= rotor_angle + $unsigned(act_vel);
      cur_a <= act_cur;
      cur_b <= act_cur >>> 1;
    end
  end
endmodule
`default_nettype wire
